// ---- hdl/pfmlp_clk_sense.sv ----
// senses a pullup on the slow crystal output pad after reset
`timescale 1ns/100ps
module pfmlp_clk_sense
    import pfmlp_pkg::*;
#(
    parameter logic [SENSE_W-1:0] HIGH_CYC = SENSE_W'(SENSE_HIGH_CYC),
    parameter logic [SENSE_W-1:0] WIN_CYC  = SENSE_W'(SENSE_WIN_CYC)
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic level_i,
    output logic      ext_clk_o,
    output logic      done_o
);
    logic [SENSE_W-1:0] hi_cnt_r;
    logic [SENSE_W-1:0] hi_cnt_nxt;
    logic [SENSE_W-1:0] win_cnt_r;
    logic [SENSE_W-1:0] win_cnt_nxt;
    logic               ext_r;
    logic               ext_nxt;
    logic               done_r;
    logic               done_nxt;

    // a running crystal toggles, a pullup stays high for HIGH_CYC cycles in a row inside the WIN_CYC window
    always_comb
    begin
        hi_cnt_nxt  = hi_cnt_r;
        win_cnt_nxt = win_cnt_r;
        ext_nxt     = ext_r;
        done_nxt    = done_r;
        if (!done_r)
        begin
            win_cnt_nxt = win_cnt_r + 1'b1;
            hi_cnt_nxt  = level_i ? hi_cnt_r + 1'b1 : '0;
            if (level_i && hi_cnt_r + 1'b1 >= HIGH_CYC)
                ext_nxt = 1'b1;
            if (win_cnt_r + 1'b1 >= WIN_CYC || ext_nxt)
                done_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hi_cnt_r  <= '0;
            win_cnt_r <= '0;
            ext_r     <= 1'b0;
            done_r    <= 1'b0;
        end
        else
        begin
            hi_cnt_r  <= hi_cnt_nxt;
            win_cnt_r <= win_cnt_nxt;
            ext_r     <= ext_nxt;
            done_r    <= done_nxt;
        end
    end

    assign ext_clk_o = ext_r;
    assign done_o    = done_r;
endmodule // pfmlp_clk_sense

// ---- hdl/pfmlp_pkg.sv ----
// constants, types and helpers shared by the pad function mux
package pfmlp_pkg;

    // ------------------------------------------------------------------
    // pads and selection codes
    // ------------------------------------------------------------------
    localparam int NPAD   = 7;
    localparam int CODE_W = 4;
    localparam int NCODE  = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // pad 0 carries general_io_bit_three, pad 6 the ninth io bit
    localparam int PAD_GENERAL_IO_BIT_THREE = 0;

    localparam logic [CODE_W-1:0] DEFAULT_CODE = 4'h0;
    localparam logic [CODE_W-1:0] ADC_CODE     = 4'hF;

    // pads that share a cell with a converter channel
    localparam logic [NPAD-1:0] ANALOG_PADS = 7'h07;

    // per pad, one bit per code: function may drive / may receive
    localparam logic [NCODE-1:0] PAD_OUT_OK [NPAD] = '{
        16'h0041, 16'h0001, 16'h0041, 16'h0021,
        16'h2C09, 16'h0081, 16'h00C9};
    localparam logic [NCODE-1:0] PAD_IN_OK [NPAD] = '{
        16'h0011, 16'h0051, 16'h00D1, 16'h00D9,
        16'h0001, 16'h1041, 16'h10C1};

    // ------------------------------------------------------------------
    // sleep pad modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SLP_HIZ, SLP_PULL, SLP_DRIVE} pfmlp_slp_e;

    localparam int SLP_LVL_BIT = 2;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SEL_BASE   = 8'h00;
    localparam logic [ADDR_W-1:0] SLP_BASE   = 8'h20;
    localparam logic [ADDR_W-1:0] STAT_ADDR  = 8'h40;
    localparam int                REG_STRIDE = 4;

    localparam int ST_STRAP = 0;
    localparam int ST_EXTCK = 1;
    localparam int ST_SENSD = 2;
    localparam int ST_BOOTD = 3;
    localparam int ST_DSLP  = 4;
    localparam int ST_HIB   = 5;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ       = 250;
    localparam int SENSE_W       = 15;
    localparam int SENSE_HIGH_NS = 40000;
    localparam int SENSE_WIN_NS  = 80000;
    localparam int SENSE_HIGH_CYC = (SENSE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int SENSE_WIN_CYC  = (SENSE_WIN_NS * CLK_MHZ) / 1000;
    localparam logic [2:0] BOOT_CYC = 3'h4;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic code_ok(input int p,
                                     input logic [CODE_W-1:0] c);
        return PAD_OUT_OK[p][c] | PAD_IN_OK[p][c] |
               ((c == ADC_CODE) & ANALOG_PADS[p]);
    endfunction

    function automatic logic [ADDR_W-1:0] reg_addr(
        input logic [ADDR_W-1:0] base, input int i);
        return base + ADDR_W'(i * REG_STRIDE);
    endfunction

endpackage

// ---- hdl/pfmlp_sync.sv ----
// two flip-flop synchroniser for pad inputs
`timescale 1ns/100ps
module pfmlp_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb
    begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;
endmodule // pfmlp_sync

// ---- hdl/pfmlp_top.sv ----
// pad function mux with reset, sleep, strap and clock-sense handling
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module pfmlp_top
    import pfmlp_pkg::*;
#(
    parameter logic [SENSE_W-1:0] SENSE_HIGH = SENSE_W'(SENSE_HIGH_CYC),
    parameter logic [SENSE_W-1:0] SENSE_WIN  = SENSE_W'(SENSE_WIN_CYC)
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic [ADDR_W-1:0]           addr_i,
    input  wire logic [DATA_W-1:0]           wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [DATA_W-1:0]           rdata_o,
    input  wire logic                        low_power_deep_sleep_i,
    input  wire logic                        hibernate_i,
    input  wire logic [NPAD-1:0][NCODE-1:0]  fn_out_i,
    input  wire logic [NPAD-1:0][NCODE-1:0]  fn_oe_i,
    output logic      [NPAD-1:0][NCODE-1:0]  fn_in_o,
    input  wire logic [NPAD-1:0]             pad_in_i,
    output logic      [NPAD-1:0]             pad_out_o,
    output logic      [NPAD-1:0]             pad_oe_n_o,
    output logic      [NPAD-1:0]             pad_pull_en_o,
    output logic      [NPAD-1:0]             pad_pull_up_o,
    output logic      [NPAD-1:0]             analog_connect_o,
    input  wire logic                        strap_pad_in_i,
    output logic                             strap_out_o,
    output logic                             strap_oe_n_o,
    output logic                             strap_pull_dn_o,
    input  wire logic                        xtal_out_pad_i,
    output logic                             slow_clk_other_pad_o,
    input  wire logic [1:0]                  ant_sel_i,
    output logic      [1:0]                  ant_sel_o
);

    // ------------------------------------------------------------------
    // pad input synchronisers
    // ------------------------------------------------------------------
    logic [NPAD-1:0] pad_sync;
    logic [1:0]      misc_sync;
    logic            ext_clk;
    logic            sense_done;

    pfmlp_sync #(
        .W         (NPAD)
    ) u_pad_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (pad_in_i),
        .sync_o    (pad_sync)
    );

    pfmlp_sync #(
        .W         (2)
    ) u_misc_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   ({xtal_out_pad_i, strap_pad_in_i}),
        .sync_o    (misc_sync)
    );

    pfmlp_clk_sense #(
        .HIGH_CYC  (SENSE_HIGH),
        .WIN_CYC   (SENSE_WIN)
    ) u_clk_sense (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .level_i   (misc_sync[1]),
        .ext_clk_o (ext_clk),
        .done_o    (sense_done)
    );

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [CODE_W-1:0] sel_r     [NPAD];
    logic [CODE_W-1:0] sel_nxt   [NPAD];
    pfmlp_slp_e        slp_r     [NPAD];
    pfmlp_slp_e        slp_nxt   [NPAD];
    logic [NPAD-1:0]   lvl_r;
    logic [NPAD-1:0]   lvl_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic              strap_cap_r;
    logic              boot_done_r;
    logic              sleep;

    assign sleep = low_power_deep_sleep_i | hibernate_i;

    always_comb
    begin
        rdata_nxt = '0;
        lvl_nxt   = lvl_r;
        for (int i = 0; i < NPAD; i++)
        begin
            sel_nxt[i] = sel_r[i];
            slp_nxt[i] = slp_r[i];
            // codes a pad does not offer are ignored
            if (wr_i && addr_i == reg_addr(SEL_BASE, i) &&
                code_ok(i, wdata_i[CODE_W-1:0]))
                sel_nxt[i] = wdata_i[CODE_W-1:0];
            if (wr_i && addr_i == reg_addr(SLP_BASE, i))
            begin
                unique case (wdata_i[1:0])
                    2'h1:    slp_nxt[i] = SLP_PULL;
                    2'h2:    slp_nxt[i] = SLP_DRIVE;
                    default: slp_nxt[i] = SLP_HIZ;
                endcase
                lvl_nxt[i] = wdata_i[SLP_LVL_BIT];
            end
            if (rd_i && addr_i == reg_addr(SEL_BASE, i))
                rdata_nxt = DATA_W'(sel_r[i]);
            if (rd_i && addr_i == reg_addr(SLP_BASE, i))
                rdata_nxt = DATA_W'({lvl_r[i], slp_r[i]});
        end
        if (rd_i && addr_i == STAT_ADDR)
        begin
            rdata_nxt[ST_STRAP] = strap_cap_r;
            rdata_nxt[ST_EXTCK] = ext_clk;
            rdata_nxt[ST_SENSD] = sense_done;
            rdata_nxt[ST_BOOTD] = boot_done_r;
            rdata_nxt[ST_DSLP]  = low_power_deep_sleep_i;
            rdata_nxt[ST_HIB]   = hibernate_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < NPAD; i++)
            begin
                sel_r[i] <= DEFAULT_CODE;
                slp_r[i] <= SLP_HIZ;
            end
            lvl_r   <= '0;
            rdata_r <= '0;
        end
        else
        begin
            sel_r   <= sel_nxt;
            slp_r   <= slp_nxt;
            lvl_r   <= lvl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // ------------------------------------------------------------------
    // pad routing
    // ------------------------------------------------------------------
    logic [NPAD-1:0]            out_r;
    logic [NPAD-1:0]            out_nxt;
    logic [NPAD-1:0]            oe_n_r;
    logic [NPAD-1:0]            oe_n_nxt;
    logic [NPAD-1:0]            pull_r;
    logic [NPAD-1:0]            pull_nxt;
    logic [NPAD-1:0]            pup_r;
    logic [NPAD-1:0]            pup_nxt;
    logic [NPAD-1:0]            ana_r;
    logic [NPAD-1:0]            ana_nxt;
    logic [NPAD-1:0][NCODE-1:0] fin_r;
    logic [NPAD-1:0][NCODE-1:0] fin_nxt;

    always_comb
    begin
        logic [CODE_W-1:0] c;
        c        = '0;
        out_nxt  = '0;
        oe_n_nxt = '1;
        pull_nxt = '0;
        pup_nxt  = '0;
        ana_nxt  = '0;
        fin_nxt  = '0;
        for (int i = 0; i < NPAD; i++)
        begin
            c = sel_r[i];
            if (sleep)
            begin
                // sleep setting overrides the active selection
                unique case (slp_r[i])
                    SLP_DRIVE:
                    begin
                        out_nxt[i]  = lvl_r[i];
                        oe_n_nxt[i] = 1'b0;
                    end
                    SLP_PULL:
                    begin
                        pull_nxt[i] = 1'b1;
                        pup_nxt[i]  = lvl_r[i];
                    end
                    SLP_HIZ:
                        oe_n_nxt[i] = 1'b1;
                endcase
            end
            else if (c == ADC_CODE && ANALOG_PADS[i])
                ana_nxt[i] = 1'b1;
            else
            begin
                out_nxt[i] = fn_out_i[i][c];
                if (PAD_OUT_OK[i][c] &&
                    (!PAD_IN_OK[i][c] || fn_oe_i[i][c]))
                    oe_n_nxt[i] = 1'b0;
                if (PAD_IN_OK[i][c])
                    fin_nxt[i][c] = pad_sync[i];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            out_r  <= '0;
            oe_n_r <= '1;
            pull_r <= '0;
            pup_r  <= '0;
            ana_r  <= '0;
            fin_r  <= '0;
        end
        else
        begin
            out_r  <= out_nxt;
            oe_n_r <= oe_n_nxt;
            pull_r <= pull_nxt;
            pup_r  <= pup_nxt;
            ana_r  <= ana_nxt;
            fin_r  <= fin_nxt;
        end
    end

    assign pad_out_o        = out_r;
    assign pad_oe_n_o       = oe_n_r;
    assign pad_pull_en_o    = pull_r;
    assign pad_pull_up_o    = pup_r;
    assign analog_connect_o = ana_r;
    assign fn_in_o          = fin_r;

    // ------------------------------------------------------------------
    // strap / oscillator enable pad, antenna select, slow clock
    // ------------------------------------------------------------------
    logic [2:0] boot_cnt_r;
    logic [2:0] boot_cnt_nxt;
    logic       boot_done_nxt;
    logic       strap_cap_nxt;
    logic       st_oe_n_r;
    logic       st_oe_n_nxt;
    logic       st_pd_r;
    logic       st_pd_nxt;
    logic [1:0] ant_r;
    logic [1:0] ant_nxt;

    // strap is read while the pad floats, then the pad turns output
    always_comb
    begin
        boot_cnt_nxt  = boot_cnt_r;
        boot_done_nxt = boot_done_r;
        strap_cap_nxt = strap_cap_r;
        ant_nxt       = ant_sel_i;
        if (!boot_done_r)
        begin
            boot_cnt_nxt = boot_cnt_r + 1'b1;
            if (boot_cnt_r + 1'b1 >= BOOT_CYC)
            begin
                boot_done_nxt = 1'b1;
                strap_cap_nxt = misc_sync[0];
            end
        end
        if (!boot_done_nxt || hibernate_i)
        begin
            st_oe_n_nxt = 1'b1;
            st_pd_nxt   = 1'b1;
        end
        else
        begin
            st_oe_n_nxt = 1'b0;
            st_pd_nxt   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            boot_cnt_r  <= '0;
            boot_done_r <= 1'b0;
            strap_cap_r <= 1'b0;
            st_oe_n_r   <= 1'b1;
            st_pd_r     <= 1'b1;
            ant_r       <= '0;
        end
        else
        begin
            boot_cnt_r  <= boot_cnt_nxt;
            boot_done_r <= boot_done_nxt;
            strap_cap_r <= strap_cap_nxt;
            st_oe_n_r   <= st_oe_n_nxt;
            st_pd_r     <= st_pd_nxt;
            ant_r       <= ant_nxt;
        end
    end

    assign strap_out_o          = 1'b1;
    assign strap_oe_n_o         = st_oe_n_r;
    assign strap_pull_dn_o      = st_pd_r;
    assign ant_sel_o            = ant_r;
    assign slow_clk_other_pad_o = ext_clk;

endmodule // pfmlp_top

// ---- test/pfmlp_board.sv ----
// board-side model of the pads, strap resistor and slow crystal
`timescale 1ns/100ps
module pfmlp_board
    import pfmlp_pkg::*;
(
    input  wire logic            sys_clk_i,
    input  wire logic [NPAD-1:0] pad_out_i,
    input  wire logic [NPAD-1:0] pad_oe_n_i,
    input  wire logic [NPAD-1:0] pull_en_i,
    input  wire logic [NPAD-1:0] pull_up_i,
    input  wire logic [NPAD-1:0] ext_en_i,
    input  wire logic [NPAD-1:0] ext_val_i,
    input  wire logic            strap_out_i,
    input  wire logic            strap_oe_n_i,
    input  wire logic            strap_res_i,
    input  wire logic            xtal_pu_i,
    output logic      [NPAD-1:0] pad_o,
    output logic                 strap_o,
    output logic                 xtal_o
);
    logic tog_r = 1'b0;

    always_ff @(posedge sys_clk_i)
        tog_r <= ~tog_r;
    // device drive wins, then board driver, then pull; a float keeps moving
    always_comb
        for (int p = 0; p < NPAD; p++)
            pad_o[p] = !pad_oe_n_i[p] ? pad_out_i[p] :
                       ext_en_i[p] ? ext_val_i[p] :
                       pull_en_i[p] ? pull_up_i[p] : tog_r;
    // only a resistor sits on the strap pad, the board never drives it
    assign strap_o = strap_oe_n_i ? strap_res_i : strap_out_i;
    // without the pullup the crystal swings every cycle
    assign xtal_o = xtal_pu_i ? 1'b1 : tog_r;
endmodule // pfmlp_board

// ---- test/pfmlp_chk.sv ----
// port assertions for the pad function mux
`timescale 1ns/100ps
module pfmlp_chk
    import pfmlp_pkg::*;
(
    input wire logic                       sys_clk_i,
    input wire logic                       rst_n_i,
    input wire logic                       wr_i,
    input wire logic                       low_power_deep_sleep_i,
    input wire logic                       hibernate_i,
    input wire logic [NPAD-1:0][NCODE-1:0] fn_out_i,
    input wire logic [NPAD-1:0][NCODE-1:0] fn_oe_i,
    input wire logic [NPAD-1:0]            pad_out_o,
    input wire logic [NPAD-1:0]            pad_oe_n_o,
    input wire logic [NPAD-1:0]            analog_connect_o,
    input wire logic                       strap_out_o,
    input wire logic                       strap_oe_n_o,
    input wire logic                       strap_pull_dn_o,
    input wire logic                       slow_clk_other_pad_o,
    input wire logic [1:0]                 ant_sel_i,
    input wire logic [1:0]                 ant_sel_o
);
    logic wrote_r;
    logic wrote_nxt;
    logic slp;

    assign slp       = low_power_deep_sleep_i | hibernate_i;
    assign wrote_nxt = wrote_r | wr_i;
    // remembers whether software has touched a register since reset
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
        if (!rst_n_i)
            wrote_r <= 1'b0;
        else
            wrote_r <= wrote_nxt;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    reset_all_hiz_a: assert property ($rose(rst_n_i) |-> &pad_oe_n_o)
        else $error("pad driven while in reset");
    boot_strap_a: assert property ($rose(rst_n_i) |->
        strap_oe_n_o [*4] ##[1:3] !strap_oe_n_o && strap_out_o)
        else $error("strap pad not driven high after boot");
    strap_hib_a: assert property ($past(hibernate_i) |->
        strap_oe_n_o && strap_pull_dn_o)
        else $error("strap pad not floating low in hibernate");
    sleep_analog_a: assert property ($past(slp) |->
        analog_connect_o == '0)
        else $error("converter connected in sleep");
    analog_pads_a: assert property (
        (analog_connect_o & ~(ANALOG_PADS & pad_oe_n_o)) == '0)
        else $error("converter on a driven or digital-only pad");
    ant_follow_a: assert property ($past(rst_n_i) |->
        ant_sel_o == $past(ant_sel_i))
        else $error("antenna select not passed through");
    sense_sticky_a: assert property ($past(slow_clk_other_pad_o) |->
        slow_clk_other_pad_o)
        else $error("external clock flag dropped");
    for (genvar p = 0; p < NPAD; p++)
    begin : g_pad
        gpio_default_a: assert property (
            !wrote_r && $past(rst_n_i) && !$past(slp) |->
            pad_oe_n_o[p] == !$past(fn_oe_i[p][0]) &&
            (pad_oe_n_o[p] || pad_out_o[p] == $past(fn_out_i[p][0])))
            else $error("pad not on general io after reset");
    end

    cover property ($fell(strap_oe_n_o));
    cover property ($rose(slow_clk_other_pad_o));
    cover property (hibernate_i ##1 strap_pull_dn_o);
endmodule // pfmlp_chk

bind pfmlp_top pfmlp_chk u_chk (.*);

// ---- test/pfmlp_top_bench.sv ----
// self-checking bench for the pad function mux
`timescale 1ns/100ps
module pfmlp_top_bench;
    import pfmlp_pkg::*;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic low_power_deep_sleep_i = 1'b0, hibernate_i = 1'b0;
    logic [ADDR_W-1:0]          addr_i = '0;
    logic [DATA_W-1:0]          wdata_i = '0, rdata_o;
    logic [NPAD-1:0][NCODE-1:0] fn_out_i = '0, fn_oe_i = '0, fn_in_o;
    logic [NPAD-1:0]            ext_en = '1, ext_val = '0, pad_in_i;
    logic [NPAD-1:0]            pad_out_o, pad_oe_n_o, analog_connect_o;
    logic [NPAD-1:0]            pad_pull_en_o, pad_pull_up_o;
    logic [1:0]                 ant_sel_i = 2'h0, ant_sel_o;
    logic strap_res = 1'b1, xtal_pu = 1'b0, strap_pad_in_i, xtal_out_pad_i;
    logic strap_out_o, strap_oe_n_o, strap_pull_dn_o, slow_clk_other_pad_o;
    int   err_count = 0, compares = 0, seed;
    int   cur [NPAD] = '{default: 0};

    pfmlp_top #(.SENSE_HIGH(15'h0008), .SENSE_WIN(15'h0010)) DUT (.*);
    pfmlp_board u_board (
        .sys_clk_i    (sys_clk_i),
        .pad_out_i    (pad_out_o),
        .pad_oe_n_i   (pad_oe_n_o),
        .pull_en_i    (pad_pull_en_o),
        .pull_up_i    (pad_pull_up_o),
        .ext_en_i     (ext_en),
        .ext_val_i    (ext_val),
        .strap_out_i  (strap_out_o),
        .strap_oe_n_i (strap_oe_n_o),
        .strap_res_i  (strap_res),
        .xtal_pu_i    (xtal_pu),
        .pad_o        (pad_in_i),
        .strap_o      (strap_pad_in_i),
        .xtal_o       (xtal_out_pad_i)
    );

    initial forever #2 sys_clk_i = ~sys_clk_i;

    task automatic summarize();
        $display("errors %0d, compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic fail(input string m);
        err_count++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic chk_pad(input logic [NPAD-1:0] g, e, input string m);
        compares++;
        if (g !== e) fail(m);
    endtask
    task automatic chk_word(input logic [DATA_W-1:0] g, e, input string m);
        compares++;
        if (g !== e) fail(m);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input int d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= DATA_W'(d);
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic do_reset();
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        wait_n(20);
        chk_pad(pad_oe_n_o, '1, "pad driven in reset");
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        cur = '{default: 0};
        wait_n(8);
    endtask
    task automatic stir();
        @(posedge sys_clk_i);
        for (int p = 0; p < NPAD; p++)
        begin
            fn_out_i[p] <= NCODE'($urandom);
            fn_oe_i[p]  <= NCODE'($urandom);
        end
        ext_val   <= NPAD'($urandom);
        ant_sel_i <= 2'($urandom);
        wait_n(6);
        chk_word(DATA_W'(ant_sel_o), DATA_W'(ant_sel_i), "antenna");
    endtask
    // expected pad state from the current code of every pad
    task automatic chk_mux();
        logic [NPAD-1:0] eo, ev, ok, an;
        int              c;
        for (int p = 0; p < NPAD; p++)
        begin
            c = cur[p];
            eo[p] = PAD_OUT_OK[p][c] ? PAD_IN_OK[p][c] & !fn_oe_i[p][c] : 1;
            ev[p] = eo[p] ? ext_val[p] : fn_out_i[p][c];
            ok[p] = fn_in_o[p] ===
                    (PAD_IN_OK[p][c] ? NCODE'(ev[p]) << c : NCODE'(0));
            an[p] = c == 15 && ANALOG_PADS[p];
        end
        chk_pad(pad_oe_n_o, eo, "pad enable");
        chk_pad(pad_out_o & ~eo, ev & ~eo, "pad drive");
        chk_pad(ok, '1, "pad input route");
        chk_pad(analog_connect_o, an, "converter connect");
    endtask

    initial
    begin
        #200000;
        fail("watchdog");
        summarize();
    end

    initial
    begin
        logic [31:0]     d;
        logic [NPAD-1:0] eo, pe, lv;
        logic [1:0]      md [NPAD];
        seed = $urandom(19);
        do_reset();
        chk_word(DATA_W'({strap_oe_n_o, strap_out_o}), 1, "strap");
        rd(STAT_ADDR, d);
        chk_word(DATA_W'({d[ST_BOOTD], d[ST_STRAP]}), 3, "boot");
        for (int k = 0; k < 12; k++)
        begin
            stir();
            chk_mux();
        end
        for (int p = 0; p < NPAD; p++)
            for (int c = 0; c < NCODE; c++)
            begin
                wr(SEL_BASE + ADDR_W'(4 * p), c);
                if (PAD_OUT_OK[p][c] | PAD_IN_OK[p][c] |
                    (c == 15 && ANALOG_PADS[p]))
                    cur[p] = c;
                stir();
                chk_mux();
                rd(SEL_BASE + ADDR_W'(4 * p), d);
                chk_word(d, DATA_W'(cur[p]), "code readback");
            end
        wr(8'h80, 1);
        rd(8'h80, d);
        chk_word(d, 0, "unmapped read");
        for (int s = 0; s < 4; s++)
        begin
            for (int p = 0; p < NPAD; p++)
            begin
                md[p] = s == 0 ? 2'(p) : 2'($urandom);
                lv[p] = 1'($urandom);
                eo[p] = md[p] != 2'h2;
                pe[p] = md[p] == 2'h1;
                wr(SLP_BASE + ADDR_W'(4 * p), {lv[p], md[p]});
            end
            @(posedge sys_clk_i);
            low_power_deep_sleep_i <= !s[0];
            hibernate_i            <= s[0];
            ext_en                 <= '0;
            wait_n(3);
            chk_pad(pad_oe_n_o, eo, "sleep enable");
            chk_pad(pad_out_o & ~eo, lv & ~eo, "sleep drive");
            chk_pad(pad_pull_en_o, pe, "sleep pull");
            chk_pad(pad_pull_up_o & pe, lv & pe, "pull level");
            chk_pad(analog_connect_o, '0, "converter in sleep");
            chk_word(DATA_W'(strap_oe_n_o), s[0], "strap sleep");
            chk_word(DATA_W'(strap_pull_dn_o | !s[0]), 1, "pulldown");
            rd(STAT_ADDR, d);
            chk_word(DATA_W'(d[ST_HIB:ST_DSLP]), 1 + s[0], "mode");
            @(posedge sys_clk_i);
            low_power_deep_sleep_i <= 1'b0;
            hibernate_i            <= 1'b0;
            ext_en                 <= '1;
            stir();
            chk_mux();
        end
        rd(STAT_ADDR, d);
        chk_word(DATA_W'(d[ST_SENSD:ST_EXTCK]), 2, "crystal kept");
        xtal_pu   <= 1'b1;
        strap_res <= 1'b0;
        do_reset();
        wait_n(40);
        chk_word(DATA_W'(slow_clk_other_pad_o), 1, "ext clock");
        rd(STAT_ADDR, d);
        chk_word(DATA_W'(d[ST_SENSD:ST_EXTCK]), 3, "sense status");
        chk_word(DATA_W'({d[ST_BOOTD], d[ST_STRAP]}), 2, "strap low");
        stir();
        chk_mux();
        summarize();
    end
endmodule // pfmlp_top_bench
